/* File: src/sps_cond.sv */
`timescale 1ns/10ps
module sps_cond
	import sps_pkg::*;
(
	input wire logic [3:0] code,
	input wire logic in_a,
	input wire logic in_b,
	input wire logic dwell_done,
	output logic met
);

	// Condition decode for one digit
	always_comb begin
		unique case (code)
			4'h0: met = 1'b1;
			4'h1: met = dwell_done;
			4'h2: met = in_a;
			4'h3: met = in_b;
			4'h4: met = !in_a;
			4'h5: met = !in_b;
			4'h6: met = in_a | in_b;
			4'h7: met = in_a & in_b;
			4'h8: met = !(in_a | in_b);
			4'h9: met = in_a & !in_b;
			4'hA: met = in_b & !in_a;
			4'hB: met = dwell_done & in_a;
			4'hC: met = dwell_done & in_b;
			4'hD: met = dwell_done & !in_a;
			4'hE: met = dwell_done & !in_b;
			4'hF: met = 1'b0;
		endcase
	end

endmodule : sps_cond

/* File: src/sps_dwell.sv */
`timescale 1ns/10ps
module sps_dwell
	import sps_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic [15:0] dwell,
	output logic done,
	output logic [15:0] tenths
);

	logic [23:0] pre_reg;
	logic [15:0] tenths_reg;
	wire pre_wrap = (pre_reg == 24'(TICKS - 1));

	// Prescaler and elapsed tenths, cleared on step entry
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_reg <= 24'h00_0000;
			tenths_reg <= 16'h0000;
		end else if (restart) begin
			pre_reg <= 24'h00_0000;
			tenths_reg <= 16'h0000;
		end else if (pre_wrap) begin
			pre_reg <= 24'h00_0000;
			if (tenths_reg != DWELL_MAX)
				tenths_reg <= tenths_reg + 16'h0001;
		end else begin
			pre_reg <= pre_reg + 24'h00_0001;
		end
	end

	assign done = (tenths_reg >= dwell);
	assign tenths = tenths_reg;

endmodule : sps_dwell

/* File: src/sps_pkg.sv */
package sps_pkg;

	// Register map, byte addresses on the register bus
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_PROG_BASE = 12'h000;
	localparam logic [11:0] OFS_DWELL_BASE = 12'h020;
	localparam logic [11:0] OFS_CTRL = 12'h040;
	localparam logic [11:0] OFS_STATUS = 12'h044;
	localparam int NUM_STEPS = 8;

	// Control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_FLTCLR_BIT = 2;
	localparam int CTRL_SRC_LSB = 8;
	localparam int CTRL_OUTF_LSB = 16;

	// Status register fields
	localparam int STAT_STEP_LSB = 0;
	localparam int STAT_RUN_BIT = 4;
	localparam int STAT_NSTOP_BIT = 5;
	localparam int STAT_COAST_BIT = 6;
	localparam int STAT_FAULT_BIT = 7;
	localparam int STAT_INA_BIT = 8;
	localparam int STAT_INB_BIT = 9;
	localparam int STAT_DWELL_BIT = 10;

	// Reset values and limits
	localparam logic [15:0] PROG_RESET = 16'h00F1;
	localparam logic [15:0] DWELL_RESET = 16'h012C;
	localparam logic [15:0] DWELL_MAX = 16'h270F;
	localparam logic [3:0] SRC_RESET = 4'h0;
	localparam logic [4:0] OUTF_RESET = 5'h00;
	localparam logic [3:0] SRC_STEP_SEQ = 4'h6;
	localparam logic [4:0] OUTF_STEP_SEQ = 5'h0F;

	// Program word digit codes
	localparam logic [3:0] COND_SKIP = 4'h0;
	localparam logic [3:0] COND_TIME = 4'h1;
	localparam logic [3:0] COND_NEVER = 4'hF;
	localparam logic [3:0] TGT_LAST_STEP = 4'h7;
	localparam logic [3:0] TGT_NORMAL = 4'h8;
	localparam logic [3:0] TGT_COAST = 4'h9;
	localparam logic [3:0] TGT_FAULT = 4'hA;
	localparam logic [3:0] D3_MAX = 4'hB;
	localparam logic [3:0] D3_SET2_MIN = 4'h6;

	// Timing: dwell resolution is 0.1 s
	localparam int CLK_PERIOD_NS = 8;
	localparam int DWELL_LSB_NS = 100_000_000;
	localparam int TICK_CYCLES = DWELL_LSB_NS / CLK_PERIOD_NS;

	// Sequencer states, Gray along idle-enter-run-ended
	typedef enum logic [1:0] {
		SPS_IDLE = 2'b00,
		SPS_ENTER = 2'b01,
		SPS_RUN = 2'b11,
		SPS_ENDED = 2'b10
	} sps_state_t;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : sps_pkg

/* File: src/sps_top.sv */
`timescale 1ns/10ps
// What this block does
// - Advance condition in digit 0 moves to next step; step 7 wraps to 0.
// - Any digit 1 code but F, when met, overrides digit 0 and jumps.
// - Digit 2 values 0 to 7 name the jump target step.
// - Jump target 8 ends with normal stop, 9 coast stop, A with fault.
// - Digit 3 codes 0-5 pick ramp set one, 6-b ramp set two.
// - With output function 15, digit 3 drives the shared output on or off.
// - Digit 3 sets direction: forward, reverse, or none, cycling by three.
// - One sequencer output shared by all steps, no per-step routing.
// - Condition code 0 counts as already met; the step is skipped.
// - Code 1 is met when time in step reaches its dwell value.
// - Codes 2,3 need input a or b active; 4,5 need it inactive.
// - Codes 6,7,8 test OR, AND, NOR; 9 and A test one-and-not-other.
// - Codes b to E combine dwell elapsed with an input state.
// - Code F never met; in digit 1 it disables the jump.
// - Eight dwell times, 0.0 to 999.9 s in 0.1 s, default 30.0 s.
// - Sequence begins only on a valid start, always at step 0.
// - Program words act only while speed source selection is 6.
// - Program word holds four hex digits, default 00F1, limit bAFF.
// - Speed index for the drive follows the current step number.
module sps_top
	import sps_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sequencer_input_a,
	input wire logic sequencer_input_b,
	output logic [2:0] speed_index,
	output logic seq_active,
	output logic accel_set2,
	output logic dir_fwd,
	output logic dir_rev,
	output logic sequencer_output,
	output logic stop_normal,
	output logic stop_coast,
	output logic external_halt_fault
);

	// Clamp a program word digit by digit to the upper limit
	function automatic logic [15:0] clamp_prog(input logic [15:0] w);
		logic [3:0] d3;
		logic [3:0] d2;
		d3 = (w[15:12] > D3_MAX) ? D3_MAX : w[15:12];
		d2 = (w[11:8] > TGT_FAULT) ? TGT_FAULT : w[11:8];
		return {d3, d2, w[7:0]};
	endfunction : clamp_prog

	// Merge the two low byte lanes into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : merge16

	logic [15:0] prog_reg [NUM_STEPS];
	logic [15:0] dwell_reg [NUM_STEPS];
	logic [3:0] src_reg;
	logic [4:0] outf_reg;
	logic start_reg;
	logic stop_reg;
	logic fltclr_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	sps_state_t state_reg;
	sps_state_t state_next;
	logic [2:0] step_reg;
	logic [2:0] step_next;
	logic fault_reg;
	logic fault_next;
	logic nstop_reg;
	logic nstop_next;
	logic coast_reg;
	logic coast_next;
	logic accel_reg;
	logic fwd_reg;
	logic rev_reg;
	logic out_reg;
	logic active_reg;
	logic dwell_done;
	logic adv_met;
	logic jump_raw;
	logic [15:0] tenths;

	// Write channel decode
	wire wr_fire = aw_full_reg & w_full_reg & !bvalid_reg;
	wire [11:0] wa = awaddr_reg;
	wire wr_prog = (wa[11:5] == OFS_PROG_BASE[11:5]);
	wire wr_dwell = (wa[11:5] == OFS_DWELL_BASE[11:5]);
	wire wr_ctrl = (wa[11:2] == OFS_CTRL[11:2]);
	wire wr_stat = (wa[11:2] == OFS_STATUS[11:2]);
	wire wr_hit = wr_prog | wr_dwell | wr_ctrl | wr_stat;
	wire [2:0] wr_idx = wa[4:2];
	wire [15:0] wd16 = wdata_reg[15:0];
	wire ctrl_w0 = wr_fire & wr_ctrl & wstrb_reg[0];

	// Read channel decode
	wire ar_fire = s_axi_arvalid & arready_reg;
	wire [11:0] ra = s_axi_araddr;
	wire rd_prog = (ra[11:5] == OFS_PROG_BASE[11:5]);
	wire rd_dwell = (ra[11:5] == OFS_DWELL_BASE[11:5]);
	wire rd_ctrl = (ra[11:2] == OFS_CTRL[11:2]);
	wire rd_stat = (ra[11:2] == OFS_STATUS[11:2]);
	wire rd_hit = rd_prog | rd_dwell | rd_ctrl | rd_stat;
	wire [2:0] rd_idx = ra[4:2];

	// Current step fields
	wire [15:0] word = prog_reg[step_reg];
	wire [3:0] dig0 = word[3:0];
	wire [3:0] dig1 = word[7:4];
	wire [3:0] dig2 = word[11:8];
	wire [3:0] dig3 = word[15:12];
	wire src_ok = (src_reg == SRC_STEP_SEQ);
	wire start_ok = start_reg & src_ok;
	wire jump_met = jump_raw & (dig1 != COND_NEVER);
	wire in_step = (state_reg == SPS_ENTER) | (state_reg == SPS_RUN);
	wire [3:0] dig3_mod3 = dig3 % 4'h3;
	wire [3:0] dig3_mod6 = dig3 % 4'h6;

	wire [31:0] ctrl_word = {11'h000, outf_reg, 4'h0, src_reg, 8'h00};
	wire [31:0] stat_word = {21'h00_0000, dwell_done, sequencer_input_b,
		sequencer_input_a, fault_reg, coast_reg, nstop_reg, in_step, 1'b0,
		step_reg};
	wire [31:0] rd_mux = rd_prog ? {16'h0000, prog_reg[rd_idx]} :
		rd_dwell ? {16'h0000, dwell_reg[rd_idx]} :
		rd_ctrl ? ctrl_word :
		rd_stat ? stat_word : 32'h0000_0000;

	// Per-step program word and dwell registers
	for (genvar i = 0; i < NUM_STEPS; i++) begin : g_step
		wire sel = wr_fire & (wr_idx == 3'(i));
		wire [15:0] pm = merge16(prog_reg[i], wd16, wstrb_reg[1:0]);
		wire [15:0] dm = merge16(dwell_reg[i], wd16, wstrb_reg[1:0]);
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				prog_reg[i] <= PROG_RESET;
				dwell_reg[i] <= DWELL_RESET;
			end else if (sel & wr_prog) begin
				prog_reg[i] <= clamp_prog(pm);
			end else if (sel & wr_dwell) begin
				dwell_reg[i] <= (dm > DWELL_MAX) ? DWELL_MAX : dm;
			end
		end
	end

	// Control register and one-cycle command pulses
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			src_reg <= SRC_RESET;
			outf_reg <= OUTF_RESET;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			fltclr_reg <= 1'b0;
		end else begin
			if (wr_fire & wr_ctrl & wstrb_reg[1])
				src_reg <= wdata_reg[CTRL_SRC_LSB +: 4];
			if (wr_fire & wr_ctrl & wstrb_reg[2])
				outf_reg <= wdata_reg[CTRL_OUTF_LSB +: 5];
			start_reg <= ctrl_w0 & wdata_reg[CTRL_START_BIT];
			stop_reg <= ctrl_w0 & wdata_reg[CTRL_STOP_BIT];
			fltclr_reg <= ctrl_w0 & wdata_reg[CTRL_FLTCLR_BIT];
		end
	end

	// Write address and data holding, either order
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (wr_fire) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
		end else begin
			if (s_axi_awvalid & awready_reg) begin
				aw_full_reg <= 1'b1;
				awready_reg <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & wready_reg) begin
				w_full_reg <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	// Write response
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read address and data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg & s_axi_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	// Dwell timer and the two condition decoders
	sps_dwell #(.TICKS(TICKS)) u_dwell (
		.core_clk(core_clk),
		.rst(rst),
		.restart(state_reg == SPS_ENTER),
		.dwell(dwell_reg[step_reg]),
		.done(dwell_done),
		.tenths(tenths)
	);
	sps_cond u_adv (
		.code(dig0),
		.in_a(sequencer_input_a),
		.in_b(sequencer_input_b),
		.dwell_done(dwell_done),
		.met(adv_met)
	);
	sps_cond u_jump (
		.code(dig1),
		.in_a(sequencer_input_a),
		.in_b(sequencer_input_b),
		.dwell_done(dwell_done),
		.met(jump_raw)
	);

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		step_next = step_reg;
		nstop_next = nstop_reg;
		coast_next = coast_reg;
		fault_next = fault_reg & !fltclr_reg;
		unique case (state_reg)
			SPS_IDLE, SPS_ENDED: begin
			end
			SPS_ENTER: state_next = SPS_RUN;
			SPS_RUN: begin
				if (jump_met) begin
					if (dig2 <= TGT_LAST_STEP) begin
						step_next = dig2[2:0];
						state_next = SPS_ENTER;
					end else begin
						state_next = SPS_ENDED;
						nstop_next = (dig2 == TGT_NORMAL);
						coast_next = (dig2 == TGT_COAST);
						fault_next = fault_next | (dig2 == TGT_FAULT);
					end
				end else if (adv_met) begin
					step_next = step_reg + 3'h1;
					state_next = SPS_ENTER;
				end
			end
		endcase
		if (start_ok) begin
			state_next = SPS_ENTER;
			step_next = 3'h0;
			nstop_next = 1'b0;
			coast_next = 1'b0;
		end
		if (stop_reg | !src_ok)
			state_next = SPS_IDLE;
	end

	// Sequencer state registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= SPS_IDLE;
			step_reg <= 3'h0;
			fault_reg <= 1'b0;
			nstop_reg <= 1'b0;
			coast_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			step_reg <= step_next;
			fault_reg <= fault_next;
			nstop_reg <= nstop_next;
			coast_reg <= coast_next;
		end
	end

	// Step settings to the drive, idle when no step is live
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			active_reg <= 1'b0;
			accel_reg <= 1'b0;
			fwd_reg <= 1'b0;
			rev_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			active_reg <= in_step;
			accel_reg <= in_step & (dig3 >= D3_SET2_MIN);
			fwd_reg <= in_step & (dig3_mod3 == 4'h0);
			rev_reg <= in_step & (dig3_mod3 == 4'h1);
			out_reg <= in_step & (outf_reg == OUTF_STEP_SEQ) &
				(dig3_mod6 >= 4'h3);
		end
	end

	assign speed_index = step_reg;
	assign seq_active = active_reg;
	assign accel_set2 = accel_reg;
	assign dir_fwd = fwd_reg;
	assign dir_rev = rev_reg;
	assign sequencer_output = out_reg;
	assign stop_normal = nstop_reg;
	assign stop_coast = coast_reg;
	assign external_halt_fault = fault_reg;
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Checks on sequencing
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire live = (state_reg == SPS_RUN) & !start_ok & !stop_reg & src_ok;

	property p_wrap;
		live & !jump_met & adv_met & (step_reg == 3'h7) |=>
			(step_reg == 3'h0) & (state_reg == SPS_ENTER);
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap to step 0");
	property p_jump;
		live & jump_met & (dig2 <= TGT_LAST_STEP) |=>
			(step_reg == $past(dig2[2:0])) & (state_reg == SPS_ENTER);
	endproperty
	a_jump: assert property (p_jump) else $error("jump missed");
	property p_end;
		live & jump_met & (dig2 > TGT_LAST_STEP) |=> (state_reg == SPS_ENDED)
			& (nstop_reg == ($past(dig2) == TGT_NORMAL))
			& (coast_reg == ($past(dig2) == TGT_COAST));
	endproperty
	a_end: assert property (p_end) else $error("bad program end");
	property p_fault;
		live & jump_met & (dig2 == TGT_FAULT) |=> external_halt_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not raised");
	property p_accel;
		in_step |=> accel_set2 == ($past(dig3) >= D3_SET2_MIN);
	endproperty
	a_accel: assert property (p_accel) else $error("wrong ramp set");
	property p_out;
		in_step & (outf_reg != OUTF_STEP_SEQ) |=> !sequencer_output;
	endproperty
	a_out: assert property (p_out) else $error("output not gated");
	property p_dir;
		in_step & (dig3 == 4'h4) |=> dir_rev & !dir_fwd;
	endproperty
	a_dir: assert property (p_dir) else $error("wrong direction");
	property p_skip;
		live & (dig0 == COND_SKIP) & (dig1 == COND_NEVER) |=>
			state_reg == SPS_ENTER;
	endproperty
	a_skip: assert property (p_skip) else $error("skip not taken");
	property p_never;
		live & (dig0 == COND_NEVER) & (dig1 == COND_NEVER) |=>
			(state_reg == SPS_RUN) & $stable(step_reg);
	endproperty
	a_never: assert property (p_never) else $error("stepped on F");
	property p_start;
		start_ok & !stop_reg |=> (step_reg == 3'h0) ##1 (tenths == 16'h0000);
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_src;
		!src_ok |=> state_reg == SPS_IDLE;
	endproperty
	a_src: assert property (p_src) else $error("ran without source");

	c_wrap: cover property (live & adv_met & (step_reg == 3'h7));
	c_jump: cover property (live & jump_met & adv_met);
	c_fault: cover property (live & jump_met & (dig2 == TGT_FAULT));
	c_out: cover property (sequencer_output);

endmodule : sps_top

/* File: verif/speed_profile_step_sequencer_bench.sv */
`timescale 1ns/10ps
module speed_profile_step_sequencer_bench;
	import sps_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, in_a = 1'b0, in_b = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] speed_index;
	logic seq_active, accel_set2, dir_fwd, dir_rev, seq_out;
	logic stop_normal, stop_coast, halt_fault;
	logic [7:0] entries;
	wire [31:0] step_w = {29'h0000_0000, speed_index};
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;

	// Short dwell tick keeps timed steps to a few cycles
	sps_top #(.TICKS(4)) dut (
		.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sequencer_input_a(in_a),
		.sequencer_input_b(in_b), .speed_index(speed_index),
		.seq_active(seq_active), .accel_set2(accel_set2),
		.dir_fwd(dir_fwd), .dir_rev(dir_rev),
		.sequencer_output(seq_out), .stop_normal(stop_normal),
		.stop_coast(stop_coast), .external_halt_fault(halt_fault)
	);
	sps_drive_model drive (
		.core_clk(core_clk), .rst(rst), .speed_index(speed_index),
		.seq_active(seq_active), .entries(entries)
	);

	always #4 core_clk = ~core_clk;
	// Cycle ceiling cuts a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count = bad_count + 1;
			report_and_stop();
		end
	end

	task automatic check_bit(input logic got, input logic exp,
		input string msg);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: %s got %b", $time, msg, got);
		end
	endtask : check_bit

	task automatic check_word(input logic [31:0] got,
		input logic [31:0] exp, input string msg);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: %s got %h", $time, msg, got);
		end
	endtask : check_word

	// Bus write, each channel released at its own handshake edge
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw;
		logic [1:0] r;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		do begin
			@(negedge core_clk);
			r = {wready, awready};
			@(posedge core_clk);
			if (!ta && r[0]) awvalid <= 1'b0;
			if (!tw && r[1]) wvalid <= 1'b0;
			ta = ta || r[0];
			tw = tw || r[1];
		end while (!(ta && tw));
		bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = bvalid;
			r = bresp;
			@(posedge core_clk);
		end while (!ta);
		bready <= 1'b0;
		check_word({30'h0000_0000, r}, {30'h0000_0000, er}, "bresp");
	endtask : axi_write

	// Bus read compared against an expected word and response
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
		input logic [1:0] er);
		logic h;
		logic [1:0] r;
		logic [31:0] d;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge core_clk);
			h = arready;
			@(posedge core_clk);
		end while (!h);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge core_clk);
			h = rvalid;
			r = rresp;
			d = rdata;
			@(posedge core_clk);
		end while (!h);
		rready <= 1'b0;
		check_word({30'h0000_0000, r}, {30'h0000_0000, er}, "rresp");
		check_word(d, x, "rdata");
	endtask : rd_chk

	task automatic set_ctrl(input logic [3:0] src, input logic [4:0] fn,
		input logic [2:0] cmd);
		axi_write(OFS_CTRL, {11'h000, fn, 4'h0, src, 5'h00, cmd}, RESP_OKAY);
	endtask : set_ctrl

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle

	// Condition by code, inputs a and b, dwell elapsed t
	function automatic logic cond_met(input logic [3:0] c, input logic a,
		input logic b, input logic t);
		logic [15:0] m;
		m = {1'b0, t & !b, t & !a, t & b, t & a, b & !a, a & !b, !(a | b),
			a & b, a | b, !b, !a, b, a, t, 1'b1};
		return m[c];
	endfunction : cond_met

	task automatic t_regs();
		rd_chk(OFS_PROG_BASE + 12'h01C, 32'h0000_00F1, RESP_OKAY);
		rd_chk(OFS_DWELL_BASE + 12'h004, 32'h0000_012C, RESP_OKAY);
		rd_chk(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		axi_write(OFS_PROG_BASE + 12'h004, 32'h0000_FFFF, RESP_OKAY);
		rd_chk(OFS_PROG_BASE + 12'h004, 32'h0000_BAFF, RESP_OKAY);
		axi_write(OFS_DWELL_BASE, 32'h0000_FFFF, RESP_OKAY);
		rd_chk(OFS_DWELL_BASE, 32'h0000_270F, RESP_OKAY);
		axi_write(12'h080, 32'h0000_0001, RESP_SLVERR);
		rd_chk(12'h080, 32'h0000_0000, RESP_SLVERR);
		$display("test regs done");
	endtask : t_regs

	task automatic t_source();
		set_ctrl(4'h0, 5'h0F, 3'h1);
		settle(4);
		check_bit(seq_active, 1'b0, "start refused");
		set_ctrl(4'h6, 5'h0F, 3'h1);
		settle(4);
		check_bit(seq_active, 1'b1, "started");
		check_word(step_w, 32'h0000_0000, "first step");
		set_ctrl(4'h0, 5'h0F, 3'h0);
		settle(3);
		check_bit(seq_active, 1'b0, "source off");
		set_ctrl(4'h6, 5'h0F, 3'h1);
		settle(4);
		check_bit(seq_active, 1'b1, "restarted");
		set_ctrl(4'h6, 5'h0F, 3'h2);
		settle(3);
		check_bit(seq_active, 1'b0, "stopped");
		$display("test source done");
	endtask : t_source

	// Every condition code against every input pair, early and late
	task automatic t_cond();
		logic e;
		axi_write(OFS_DWELL_BASE, 32'h0000_0003, RESP_OKAY);
		axi_write(OFS_PROG_BASE + 12'h004, 32'h0000_00FF, RESP_OKAY);
		for (int n = 0; n < 64; n++) begin
			@(posedge core_clk);
			in_a <= n[0];
			in_b <= n[1];
			axi_write(OFS_PROG_BASE, 32'h0000_00F0 + 32'(n >> 2), RESP_OKAY);
			set_ctrl(4'h6, 5'h0F, 3'h1);
			settle(6);
			e = cond_met(4'(n >> 2), n[0], n[1], 1'b0);
			check_bit(speed_index[0], e, "early");
			settle(24);
			e = cond_met(4'(n >> 2), n[0], n[1], 1'b1);
			check_bit(speed_index[0], e, "late");
		end
		$display("test cond done");
	endtask : t_cond

	// Walk all steps twice; step settings cover codes 0 to b
	task automatic t_steps();
		logic [3:0] d;
		logic [7:0] e0;
		@(posedge core_clk);
		in_a <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				d = 4'(p * 4 + i);
				axi_write(OFS_PROG_BASE + 12'(4 * i),
					{16'h0000, d, 8'h0F, i[0] ? 4'h4 : 4'h2}, RESP_OKAY);
			end
			set_ctrl(4'h6, 5'h0F, 3'h1);
			settle(4);
			e0 = entries;
			for (int i = 0; i < 8; i++) begin
				d = 4'(p * 4 + i);
				check_word(step_w, 32'(i), "step");
				check_bit(accel_set2, d >= 4'h6, "ramp");
				check_bit(dir_fwd, d % 3 == 0, "fwd");
				check_bit(dir_rev, d % 3 == 1, "rev");
				check_bit(seq_out, d % 6 >= 3, "out");
				@(posedge core_clk);
				in_a <= !i[0];
				settle(8);
			end
			check_word(step_w, 32'h0000_0000, "wrap");
			check_word(32'(entries - e0), 32'h0000_0008, "entries");
		end
		check_bit(seq_out, 1'b1, "out on");
		set_ctrl(4'h6, 5'h00, 3'h0);
		settle(2);
		check_bit(seq_out, 1'b0, "out gated");
		$display("test steps done");
	endtask : t_steps

	// Jump beats a skip advance; targets 2 to A
	task automatic t_jump();
		for (int i = 1; i < 8; i++)
			axi_write(OFS_PROG_BASE + 12'(4 * i), 32'h0000_00FF, RESP_OKAY);
		@(posedge core_clk);
		in_a <= 1'b1;
		for (int j = 2; j < 11; j++) begin
			axi_write(OFS_PROG_BASE, {20'h0_0000, 4'(j), 8'h20}, RESP_OKAY);
			set_ctrl(4'h6, 5'h0F, 3'h1);
			settle(8);
			if (j < 8) check_word(step_w, 32'(j), "jump");
			check_bit(seq_active, j < 8, "active");
			check_bit(stop_normal, j == 8, "normal");
			check_bit(stop_coast, j == 9, "coast");
			check_bit(halt_fault, j == 10, "fault");
		end
		set_ctrl(4'h6, 5'h0F, 3'h4);
		settle(2);
		check_bit(halt_fault, 1'b0, "fault clear");
		@(posedge core_clk);
		in_a <= 1'b0;
		$display("test jump done");
	endtask : t_jump

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_source();
		t_cond();
		t_steps();
		t_jump();
		report_and_stop();
	end
endmodule : speed_profile_step_sequencer_bench

/* File: verif/sps_drive_model.sv */
`timescale 1ns/10ps
// Drive side: counts new preset indexes handed over while a step runs
module sps_drive_model
	import sps_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [2:0] speed_index,
	input wire logic seq_active,
	output logic [7:0] entries
);
	logic [2:0] last_reg;
	// An index change while active is one step entry
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_reg <= 3'h0;
			entries <= 8'h00;
		end else begin
			last_reg <= speed_index;
			if (seq_active && speed_index != last_reg)
				entries <= entries + 8'h01;
		end
	end
endmodule : sps_drive_model
